//--- core/acpc_ctrl.sv
// calibration sequencing, conversion scaling and parity readout
// How it works
// - parity only while parity_enable_bit set
// - parity bit makes result plus status even
// - four calibration modes, startable any time
// - subtract offset, multiply full-scale, then store
// - calibration start drives ready bit, pin high
// - completion updates coefficient, clears ready, idles
// - internal cal connects zero/full input internally
// - no chop: zero cal four/three periods
// - chop: zero cals take two periods
// - internal full cal doubles above gain one
// - system full cal takes one settling time
// - coefficients readable always, writable idle/power-down
// - sync pulse or mode/config write resets modulator
// - missing reference during calibration inhibits update, sets error
`timescale 1ns/1ps
module acpc_ctrl
  import acpc_pkg::*;
(
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          rst,
  // register port
  input  wire logic [AW-1:0] reg_addr,
  input  wire logic [DW-1:0] reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [DW-1:0] reg_rdata,
  // converter core, same clock
  input  wire logic [23:0]   raw_data,
  input  wire logic          raw_valid,
  output logic               mod_reset,
  output logic               zero_connect,
  output logic               full_connect,
  output logic               clk_div,
  // pins
  input  wire logic          sync_n,
  input  wire logic          cs_n,
  input  wire logic          sclk,
  input  wire logic          ref_missing_flag,
  output logic               dout_rdy,
  output logic               dout_rdy_oe_n
);
  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  logic [3:0] pin_in;
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  assign pin_in = {ref_missing_flag, sclk, cs_n, sync_n};

  // two flops per pin, first one read only by the second
  // reset to each pin's idle level so no false edge follows reset
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          pin_s1[gi] <= PIN_IDLE[gi];
          pin_s2[gi] <= PIN_IDLE[gi];
        end else begin
          pin_s1[gi] <= pin_in[gi];
          pin_s2[gi] <= pin_s1[gi];
        end
      end
    end
  endgenerate

  wire sync_s = pin_s2[0];
  wire cs_s   = pin_s2[1];
  wire sclk_s = pin_s2[2];
  wire nref_s = pin_s2[3];
  logic sclk_d;
  wire  sclk_fall = sclk_d & ~sclk_s;

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  acpc_mode_t  mode;
  acpc_cfg_t   cfg;
  acpc_stat_t  stat;
  acpc_cal_t   cal_st;
  // result and coefficient words
  logic [23:0] data;
  logic [23:0] offs;
  logic [23:0] fsc;
  // calibration progress
  logic [3:0]  cal_cnt;
  logic [3:0]  cal_len;
  logic [2:0]  cal_op;
  logic        cal_err;
  // serial shifter
  logic [31:0] sh_reg;
  logic [5:0]  sh_cnt;
  logic        sh_act;

  // write decode
  // coefficient writes are refused outside idle and power-down
  wire wr_mode = reg_wr & (reg_addr == OFS_MODE);
  wire wr_cfg  = reg_wr & (reg_addr == OFS_CFG);
  wire coef_ok = (mode.op == OP_IDLE) | (mode.op == OP_PDOWN);
  wire wr_offs = reg_wr & (reg_addr == OFS_OFFS) & coef_ok;
  wire wr_fsc  = reg_wr & (reg_addr == OFS_FSC) & coef_ok;
  wire rd_data = reg_rd & (reg_addr == OFS_DATA);

  // mode write fields, reserved bits kept at zero
  acpc_mode_t  wmode;
  acpc_cfg_t   wcfg;
  assign wmode = '{op: reg_wdata[23:21], stat_app: reg_wdata[20], rsv_a: 4'h0,
                   sinc3: reg_wdata[15], rsv_b: 1'b0, par_en: reg_wdata[13],
                   rsv_c: 1'b0, clk_div: reg_wdata[11], rsv_d: 1'b0,
                   filt: reg_wdata[9:0]};
  assign wcfg  = '{chop: reg_wdata[23], rsv: 20'h0, gain: reg_wdata[2:0]};

  // -----------------------------------------------------------------
  // calibration timing
  // -----------------------------------------------------------------
  wire        cal_req  = wr_mode & wmode.op[2];
  // filter choice comes from the word being written, not the old mode
  wire [3:0]  settle   = cfg.chop ? SETTLE_CHOP :
                         (wmode.sinc3 ? SETTLE_SINC3 : SETTLE_SINC4);
  wire [2:0]  req_op   = wmode.op;
  // internal full-scale doubles above unity gain; filt%16 is host's duty
  wire        dbl      = (req_op == OP_IFULL) & (cfg.gain != GAIN_ONE);
  wire [3:0]  req_len  = dbl ? {settle[2:0], 1'b0} : settle;
  wire        cal_busy = (cal_st == CAL_BUSY);
  // a mode write in the end cycle aborts, so no late coefficient load
  wire        cal_end  = cal_busy & raw_valid & ~wr_mode & (cal_cnt + 4'h1 == cal_len);
  wire        is_zero  = (cal_op == OP_IZERO) | (cal_op == OP_SZERO);

  // internal cals route the reference inputs to the modulator
  assign zero_connect = cal_busy & (cal_op == OP_IZERO);
  assign full_connect = cal_busy & (cal_op == OP_IFULL);

  // calibration state
  acpc_cal_t next_cal_st;
  always_comb begin
    next_cal_st = cal_st;
    unique case (cal_st)
      CAL_OFF:  if (cal_req) next_cal_st = CAL_BUSY;
      CAL_BUSY: if (cal_req) next_cal_st = CAL_BUSY;
                else if (wr_mode | cal_end) next_cal_st = CAL_OFF;
      default:  next_cal_st = CAL_OFF;
    endcase
  end

  // settle counter counts raw_valid ticks after the start edge
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cal_st  <= CAL_OFF;
      cal_cnt <= 4'h0;
      cal_len <= SETTLE_SINC4;
      cal_op  <= OP_IZERO;
      cal_err <= 1'b0;
    end else begin
      cal_st <= next_cal_st;
      if (cal_req) begin
        cal_cnt <= 4'h0;
        cal_len <= req_len;
        cal_op  <= req_op;
        cal_err <= 1'b0;
      end else begin
        if (cal_busy & raw_valid) cal_cnt <= cal_cnt + 4'h1;
        if (cal_busy & nref_s) cal_err <= 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------
  // conversion scaling
  // -----------------------------------------------------------------
  // negative results clamp to zero, overflow to all ones
  wire signed [24:0] diff   = $signed({1'b0, raw_data}) - $signed({1'b0, offs});
  wire signed [49:0] prod   = diff * $signed({1'b0, fsc});
  wire signed [26:0] scaled = prod[FS_FRAC+26:FS_FRAC];
  wire [23:0] clamped = scaled[26] ? 24'h000000 :
                        (|scaled[25:24] ? DATA_ONES : scaled[23:0]);
  wire conv_mode = (mode.op == OP_CONT) | (mode.op == OP_SINGLE);
  wire conv_new  = raw_valid & conv_mode & ~cal_busy & ~wr_mode;
  wire [23:0] next_data = nref_s ? DATA_ONES : clamped;

  // stored value, coefficients and mode
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode <= acpc_mode_t'(MODE_RST);
      cfg  <= acpc_cfg_t'(CFG_RST);
      data <= 24'h000000;
      offs <= OFFS_RST;
      fsc  <= FSC_RST;
    end else begin
      if (wr_mode) mode <= wmode;
      else if (cal_end | (conv_new & (mode.op == OP_SINGLE))) mode.op <= OP_IDLE;
      if (wr_cfg) cfg <= wcfg;
      if (conv_new) data <= next_data;
      if (wr_offs) offs <= reg_wdata;
      else if (cal_end & is_zero & ~cal_err & ~nref_s) offs <= raw_data;
      if (wr_fsc) fsc <= reg_wdata;
      else if (cal_end & ~is_zero & ~cal_err & ~nref_s) fsc <= raw_data;
    end
  end

  // -----------------------------------------------------------------
  // status and parity
  // -----------------------------------------------------------------
  // parity covers every bit that leaves in the frame
  wire        par_bit = mode.par_en &
                        (^{data, stat.ready, stat.err, nref_s});
  acpc_stat_t stat_word;
  assign stat_word = '{ready: stat.ready, err: stat.err, ref_missing: nref_s,
                       parity: par_bit, rsv: 4'h0};
  wire xfer_done = sh_act & sclk_fall & (sh_cnt == 6'h01);

  // ready high means busy or already read; hardware clear wins over read
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stat <= '{ready: 1'b1, err: 1'b0, ref_missing: 1'b0, parity: 1'b0, rsv: 4'h0};
    end else begin
      stat.ref_missing <= nref_s;
      stat.parity      <= par_bit;
      if (rd_data | xfer_done) stat.ready <= 1'b1;
      if (cal_req) stat.ready <= 1'b1;
      if (cal_end | conv_new) stat.ready <= 1'b0;
      if (cal_req) stat.err <= 1'b0;
      if (cal_end & (cal_err | nref_s)) stat.err <= 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // register readback
  // -----------------------------------------------------------------
  // unmapped addresses read as zero
  logic [DW-1:0] rd_mux;
  assign rd_mux = (reg_addr == OFS_STAT) ? {16'h0000, stat_word} :
                  (reg_addr == OFS_MODE) ? mode :
                  (reg_addr == OFS_CFG)  ? cfg  :
                  (reg_addr == OFS_DATA) ? data :
                  (reg_addr == OFS_OFFS) ? offs :
                  (reg_addr == OFS_FSC)  ? fsc  : 24'h000000;

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) reg_rdata <= 24'h000000;
    else     reg_rdata <= reg_rd ? rd_mux : 24'h000000;
  end

  // -----------------------------------------------------------------
  // serial readout of result and status
  // -----------------------------------------------------------------
  wire sh_start = ~sh_act & ~cs_s & ~stat.ready & sclk_fall;
  // status byte follows only when the host asked for it
  wire [5:0] sh_len = mode.stat_app ? XFER_FULL : XFER_DATA;
  // bit on the pin: the shifted msb shows one clock after each falling edge
  wire       sh_bit = sh_start ? data[23] : (sclk_fall ? sh_reg[30] : sh_reg[31]);

  // cs high aborts a frame and leaves ready as it was
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sclk_d <= 1'b1;
      sh_act <= 1'b0;
      sh_cnt <= 6'h00;
      sh_reg <= 32'h00000000;
    end else begin
      sclk_d <= sclk_s;
      if (cs_s) begin
        sh_act <= 1'b0;
      end else if (sh_start) begin
        sh_act <= 1'b1;
        // first falling edge already puts out the first bit
        sh_cnt <= sh_len - 6'h01;
        sh_reg <= {data, stat_word};
      end else if (sh_act & sclk_fall) begin
        sh_cnt <= sh_cnt - 6'h01;
        sh_reg <= {sh_reg[30:0], 1'b0};
        if (sh_cnt == 6'h01) sh_act <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // pin and core outputs
  // -----------------------------------------------------------------
  // pin shows the frame bit while shifting, ready level otherwise
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dout_rdy      <= 1'b1;
      dout_rdy_oe_n <= 1'b1;
      mod_reset     <= 1'b1;
      clk_div       <= 1'b0;
    end else begin
      dout_rdy      <= (sh_act | sh_start) ? sh_bit : stat.ready;
      dout_rdy_oe_n <= cs_s; // pin floats while deselected
      mod_reset     <= ~sync_s | wr_mode | wr_cfg;
      clk_div       <= mode.clk_div;
    end
  end

endmodule // acpc_ctrl

//--- shared/acpc_pkg.sv
// constants and carriers for the calibration and parity controller
package acpc_pkg;
  // -----------------------------------------------------------------
  // register port
  // -----------------------------------------------------------------
  localparam int unsigned AW        = 3;
  localparam int unsigned DW        = 24;
  localparam logic [2:0]  OFS_STAT  = 3'h0;
  localparam logic [2:0]  OFS_MODE  = 3'h1;
  localparam logic [2:0]  OFS_CFG   = 3'h2;
  localparam logic [2:0]  OFS_DATA  = 3'h3;
  localparam logic [2:0]  OFS_OFFS  = 3'h4;
  localparam logic [2:0]  OFS_FSC   = 3'h5;
  // -----------------------------------------------------------------
  // operation mode field codes
  // -----------------------------------------------------------------
  localparam logic [2:0]  OP_CONT   = 3'h0;
  localparam logic [2:0]  OP_SINGLE = 3'h1;
  localparam logic [2:0]  OP_IDLE   = 3'h2;
  localparam logic [2:0]  OP_PDOWN  = 3'h3;
  localparam logic [2:0]  OP_IZERO  = 3'h4;
  localparam logic [2:0]  OP_IFULL  = 3'h5;
  localparam logic [2:0]  OP_SZERO  = 3'h6;
  localparam logic [2:0]  OP_SFULL  = 3'h7;
  // -----------------------------------------------------------------
  // settling time in output-rate periods
  // -----------------------------------------------------------------
  localparam logic [3:0]  SETTLE_SINC4 = 4'h4;
  localparam logic [3:0]  SETTLE_SINC3 = 4'h3;
  localparam logic [3:0]  SETTLE_CHOP  = 4'h2;
  localparam logic [2:0]  GAIN_ONE     = 3'h0;
  // -----------------------------------------------------------------
  // reset values, scaling, serial lengths
  // -----------------------------------------------------------------
  localparam logic [23:0] MODE_RST  = 24'h000060;
  localparam logic [23:0] CFG_RST   = 24'h000000;
  localparam logic [23:0] OFFS_RST  = 24'h000000;
  localparam logic [23:0] FSC_RST   = 24'h800000;
  localparam logic [23:0] DATA_ONES = 24'hffffff;
  localparam int unsigned FS_FRAC   = 23;
  localparam logic [5:0]  XFER_DATA = 6'h18;
  localparam logic [5:0]  XFER_FULL = 6'h20;
  // idle levels of {ref_missing_flag, sclk, cs_n, sync_n}
  localparam logic [3:0]  PIN_IDLE  = 4'h7;
  // -----------------------------------------------------------------
  // register layouts
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] op;
    logic       stat_app;
    logic [3:0] rsv_a;
    logic       sinc3;
    logic       rsv_b;
    logic       par_en;
    logic       rsv_c;
    logic       clk_div;
    logic       rsv_d;
    logic [9:0] filt;
  } acpc_mode_t;
  typedef struct packed {
    logic        chop;
    logic [19:0] rsv;
    logic [2:0]  gain;
  } acpc_cfg_t;
  typedef struct packed {
    logic       ready;
    logic       err;
    logic       ref_missing;
    logic       parity;
    logic [3:0] rsv;
  } acpc_stat_t;
  typedef enum logic [1:0] {
    CAL_OFF  = 2'b01,
    CAL_BUSY = 2'b10
  } acpc_cal_t;
endpackage

//--- testbench/acpc_ctrl_checker.sv
// port assertions for the calibration and parity controller
`timescale 1ns/1ps
module acpc_ctrl_checker
  import acpc_pkg::*;
(
  // clock and reset
  input wire logic          mclk,
  input wire logic          rst,
  // register port
  input wire logic [AW-1:0] reg_addr,
  input wire logic [DW-1:0] reg_wdata,
  input wire logic          reg_wr,
  input wire logic          reg_rd,
  input wire logic [DW-1:0] reg_rdata,
  // converter side
  input wire logic          mod_reset,
  input wire logic          zero_connect,
  input wire logic          full_connect,
  // pins
  input wire logic          sync_n,
  input wire logic          cs_n,
  input wire logic          ref_missing_flag,
  input wire logic          dout_rdy,
  input wire logic          dout_rdy_oe_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // decoded register writes
  wire logic mode_wr = reg_wr && reg_addr == OFS_MODE;
  wire logic cfg_wr  = reg_wr && reg_addr == OFS_CFG;
  wire logic cal_wr  = mode_wr && reg_wdata[23];
  // properties
  property p_rd; !$past(reg_rd) |-> reg_rdata == '0; endproperty
  property p_cal; cal_wr |-> ##2 dout_rdy [*2]; endproperty
  property p_mwr; (mode_wr || cfg_wr) |=> mod_reset; endproperty
  property p_syn; !sync_n [*5] |-> mod_reset; endproperty
  property p_oeh; cs_n [*5] |-> dout_rdy_oe_n; endproperty
  property p_oel; !cs_n [*5] |-> !dout_rdy_oe_n; endproperty
  property p_zc; cal_wr && reg_wdata[23:21] == OP_IZERO |=> zero_connect; endproperty
  property p_fc; cal_wr && reg_wdata[23:21] == OP_IFULL |=> full_connect; endproperty
  a_rd: assert property (p_rd) else $error("read data outside its slot");
  a_cal: assert property (p_cal) else $error("pin not high after cal start");
  a_mwr: assert property (p_mwr) else $error("no modulator reset on write");
  a_syn: assert property (p_syn) else $error("no modulator reset on sync");
  a_oeh: assert property (p_oeh) else $error("pin driven while deselected");
  a_oel: assert property (p_oel) else $error("pin released while selected");
  a_zc: assert property (p_zc) else $error("zero input not connected");
  a_fc: assert property (p_fc) else $error("full input not connected");
  // main scenarios
  c_cal: cover property (cal_wr);
  c_syn: cover property (!sync_n [*5]);
  c_ref: cover property (ref_missing_flag && dout_rdy);
endmodule // acpc_ctrl_checker

bind acpc_ctrl acpc_ctrl_checker chk (
  .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mod_reset(mod_reset), .zero_connect(zero_connect),
  .full_connect(full_connect), .sync_n(sync_n), .cs_n(cs_n), .dout_rdy(dout_rdy),
  .ref_missing_flag(ref_missing_flag), .dout_rdy_oe_n(dout_rdy_oe_n)
);

//--- testbench/acpc_host.sv
// host processor model on the three-wire serial port
`timescale 1ns/1ps
module acpc_host (
  // serial pins
  input  wire logic dout_rdy,
  output logic      sclk,
  output logic      cs_n
);
  // serial clock idles high outside frames
  initial begin
    sclk = 1'b1;
    cs_n = 1'b0;
  end
  // chip select level
  task automatic sel(input logic v);
    cs_n <= v;
  endtask
  // clock a frame in msb first, 160 ns per bit
  task automatic xfer(input int nb, output logic [31:0] fr, output logic ok);
    fr = '0;
    for (int i = 0; i < nb; i++) begin
      sclk <= 1'b0;
      #75 fr = {fr[30:0], dout_rdy};
      #5 sclk <= 1'b1;
      #80;
    end
    ok = ~^fr; // odd count of ones means corrupted
  endtask
endmodule // acpc_host

//--- testbench/tb_adc_calibration_parity_ctrl.sv
// self-checking bench for the calibration and parity controller
`timescale 1ns/1ps
module tb_adc_calibration_parity_ctrl import acpc_pkg::*;;
  logic          mclk, rst, reg_wr, reg_rd, raw_valid, sync_n, ref_missing_flag;
  logic [AW-1:0] reg_addr;
  logic [DW-1:0] reg_wdata, rd_val;
  logic [23:0]   raw_data;
  wire  logic [DW-1:0] reg_rdata;
  wire  logic    mod_reset, zero_connect, full_connect, clk_div, sclk, cs_n, dout_rdy, oe_n;
  int            num_errors, total_checks, cyc;
  acpc_ctrl uut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .raw_data(raw_data),
    .raw_valid(raw_valid), .mod_reset(mod_reset), .zero_connect(zero_connect),
    .full_connect(full_connect), .clk_div(clk_div), .sync_n(sync_n), .cs_n(cs_n),
    .sclk(sclk), .ref_missing_flag(ref_missing_flag), .dout_rdy(dout_rdy),
    .dout_rdy_oe_n(oe_n));
  acpc_host host (.dout_rdy(dout_rdy), .sclk(sclk), .cs_n(cs_n));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // register port cycles
  task automatic wr(input logic [2:0] a, input logic [23:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  task automatic rdc(input logic [2:0] a, input logic [23:0] e);
    rd(a);
    chk(rd_val, e);
  endtask
  // one output-rate tick
  task automatic pulse(input logic [23:0] v);
    @(posedge mclk);
    raw_data  <= v;
    raw_valid <= 1'b1;
    @(posedge mclk);
    raw_valid <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  // mode word, filter word 0x60 is a multiple of 16
  function automatic logic [23:0] mw(input logic [2:0] op, input logic sa, s3, pe);
    acpc_mode_t m;
    m = '0;
    m.op = op;
    m.stat_app = sa;
    m.sinc3 = s3;
    m.par_en = pe;
    m.clk_div = (op == OP_IFULL);
    m.filt = 10'h060;
    return m;
  endfunction
  task automatic t_reset();
    rdc(OFS_MODE, MODE_RST);
    rdc(OFS_FSC, FSC_RST);
    rdc(3'h6, 24'h0);
    host.sel(1'b1);
    repeat (8) @(posedge mclk);
    #1 chk(oe_n, 1'b1);
    host.sel(1'b0);
    sync_n <= 1'b0;
    repeat (6) @(posedge mclk);
    #1 chk(mod_reset, 1'b1);
    @(posedge mclk) sync_n <= 1'b1;
  endtask
  // run one calibration, drive n ticks and check the pin falls only on the n-th
  task automatic t_cal(input logic [2:0] op, input logic ch, input logic [2:0] g,
                       input logic s3, input int n, input logic rm);
    logic [2:0]  ca;
    logic [23:0] old;
    ca = op[0] ? OFS_FSC : OFS_OFFS;
    rd(ca);
    old = rd_val;
    wr(OFS_CFG, {ch, 20'h0, g});
    ref_missing_flag <= rm;
    wr(OFS_MODE, mw(op, 1'b0, s3, 1'b0));
    for (int k = 1; k <= n; k++) begin
      pulse(24'h100 + 24'(k));
      chk(dout_rdy, k < n);
    end
    chk(clk_div, op == OP_IFULL);
    @(posedge mclk) ref_missing_flag <= 1'b0;
    rdc(ca, rm ? old : 24'h100 + 24'(n));
    rd(OFS_MODE);
    chk(rd_val[23:21], OP_IDLE);
    rd(OFS_STAT);
    chk(rd_val[6], rm);
  endtask
  task automatic t_coef();
    wr(OFS_OFFS, 24'h000002);
    wr(OFS_FSC, 24'h400000);
    rdc(OFS_FSC, 24'h400000);
    wr(OFS_MODE, mw(OP_CONT, 1'b1, 1'b0, 1'b1));
    wr(OFS_OFFS, 24'h000009);
    rdc(OFS_OFFS, 24'h000002);
  endtask
  // conversion read with status appended
  task automatic t_par(input logic pe, input logic [23:0] raw, input logic [23:0] e);
    logic [31:0] fr;
    logic        ok;
    wr(OFS_MODE, mw(OP_CONT, 1'b1, 1'b0, pe));
    pulse(raw);
    host.xfer(32, fr, ok);
    chk(fr[31:8], e);
    chk(pe ? ok : fr[4], pe);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end
  end
  initial begin
    {rst, sync_n} = 2'b11;
    {reg_wr, reg_rd, raw_valid, ref_missing_flag} = 4'h0;
    reg_addr = '0;
    reg_wdata = '0;
    raw_data = '0;
    {num_errors, total_checks, cyc} = '0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_cal(OP_IZERO, 1'b0, 3'h0, 1'b0, 4, 1'b0);
    t_cal(OP_SZERO, 1'b0, 3'h0, 1'b1, 3, 1'b0);
    t_cal(OP_IZERO, 1'b1, 3'h0, 1'b0, 2, 1'b0);
    t_cal(OP_SZERO, 1'b1, 3'h0, 1'b1, 2, 1'b0);
    t_cal(OP_IFULL, 1'b0, 3'h0, 1'b0, 4, 1'b0);
    t_cal(OP_IFULL, 1'b0, 3'h2, 1'b1, 6, 1'b0);
    t_cal(OP_SFULL, 1'b0, 3'h1, 1'b0, 4, 1'b0);
    t_cal(OP_SZERO, 1'b0, 3'h0, 1'b0, 4, 1'b1);
    t_coef();
    t_par(1'b1, 24'h000010, 24'h000007);
    t_par(1'b0, 24'h000012, 24'h000008);
    end_sim();
  end
endmodule // tb_adc_calibration_parity_ctrl
